/* File: hdl/rtr_regs.sv */
// rtr_regs: receive tuning register bank with test dac path.
// assumes demod samples, rssi and sync detect come from clk_i logic.
`timescale 1ns/1ps
module rtr_regs
   import rtr_pkg::*;
#(
   parameter int SW = 16,
   parameter int RW = 7
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // receive path
   input wire logic signed [SW-1:0] lin_sample_i,
   input wire logic signed [SW-1:0] corr_sample_i,
   input wire logic [RW-1:0] rssi_i,
   input wire logic sync_det_i,
   input wire logic recovered_bit_i,
   // controls out
   output logic trsw_enable_o,
   output logic [1:0] lna_gain_o,
   output logic loop_hold_o,
   output logic demod_tick_o,
   output logic recovery_tick_o,
   output logic recovered_valid_o,
   output logic recovered_bit_o,
   output logic [11:0] tune_o,
   output logic [19:0] corr_range_hz_o,
   output logic swd_o
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // byte-lane merge for a wishbone write
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction

   // clamp a wide signed value into the sample width
   function automatic logic signed [SW-1:0] sat(
      input logic signed [SW+15:0] v);
      logic signed [SW+15:0] mx;
      mx = (SW+16)'((1 <<< (SW-1)) - 1);
      if (v > mx) return SW'(mx);
      else if (v < -mx - 1) return SW'(-mx - 1);
      else return SW'(v);
   endfunction

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic req;
   logic wr;
   logic ack_ff;
   logic [31:0] rdat_ff;
   logic [31:0] nxt_rdat;

   // request taken while ack is low; a write lands at the ack edge
   assign req = wb_cyc_i && wb_stb_i && !ack_ff;
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;

   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   logic [31:0] pdtest_ff;
   rtr_gain_cfg_t gain_ff;
   rtr_freq_cfg_t freq_ff;
   logic lock_ff;
   logic [3:0] tmode_ff;
   rtr_tune_t tune_ff;
   rtr_dac_cfg_t dac_ff;
   logic dac_on_ff;
   logic [7:0] demdiv_ff;
   logic [7:0] recdiv_ff;
   logic [7:0] seqdiv_ff;
   logic halve_ff;
   logic [31:0] wv;

   // merged write value of the addressed register
   always_comb begin
      case (wb_adr_i)
         RTR_PDTEST_OFS: wv = merge(pdtest_ff, wb_dat_i, wb_sel_i);
         RTR_GAINCTRL_OFS: wv = merge({6'h0, gain_ff.low_noise_amp_gain_mode,
            7'h0, gain_ff.lna_gain, 1'b0, gain_ff.high, 1'b0,
            gain_ff.low}, wb_dat_i, wb_sel_i);
         RTR_FREQCORR_OFS: wv = merge({freq_ff.limit, 5'h0,
            freq_ff.kp, freq_ff.ki, freq_ff.scale}, wb_dat_i, wb_sel_i);
         RTR_TESTDAC_OFS: wv = merge({11'h0, dac_ff}, wb_dat_i,
            wb_sel_i);
         RTR_CLKCTRL_OFS: wv = merge({7'h0, halve_ff, seqdiv_ff,
            recdiv_ff, demdiv_ff}, wb_dat_i, wb_sel_i);
         default: wv = merge(RTR_ZERO, wb_dat_i, wb_sel_i);
      endcase
   end

   // power-down test register; only the switch bit is kept
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pdtest_ff <= RTR_ZERO;
      end else if (wr && wb_adr_i == RTR_PDTEST_OFS) begin
         pdtest_ff <= wv & (32'h1 << RTR_TRSW_OFF_BIT);
      end
   end

   // gain control thresholds and amplifier mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gain_ff.low <= RTR_LOW_RST;
         gain_ff.high <= RTR_HIGH_RST;
         gain_ff.lna_gain <= RTR_LNA_GAIN30;
         gain_ff.low_noise_amp_gain_mode <= 1'b0;
      end else if (wr && wb_adr_i == RTR_GAINCTRL_OFS) begin
         gain_ff.low <= wv[RTR_LOW_LSB +: 7];
         gain_ff.high <= wv[RTR_HIGH_LSB +: 7];
         gain_ff.lna_gain <= wv[RTR_LNA_GAIN_LSB +: 2];
         gain_ff.low_noise_amp_gain_mode <= wv[RTR_LOW_NOISE_AMP_GAIN_MODE_BIT];
      end
   end

   // frequency correction settings; loop gains start at 11 and 4
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         freq_ff.scale <= RTR_SCALE_RST;
         freq_ff.ki <= RTR_KI_RST;
         freq_ff.kp <= RTR_KP_RST;
         freq_ff.limit <= RTR_LIMIT_RST;
      end else if (wr && wb_adr_i == RTR_FREQCORR_OFS) begin
         freq_ff.scale <= wv[RTR_SCALE_LSB +: 12];
         freq_ff.ki <= wv[RTR_KI_LSB +: 4];
         freq_ff.kp <= wv[RTR_KP_LSB +: 3];
         freq_ff.limit <= wv[RTR_LIMIT_LSB +: 8];
      end
   end

   // lock threshold, test mode key and tuning parameters
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_ff <= 1'b0;
         tmode_ff <= 4'h0;
         tune_ff <= '0;
      end else if (wr) begin
         if (wb_adr_i == RTR_THRESH_OFS && wb_sel_i[0])
            lock_ff <= wb_dat_i[RTR_LOCK_BIT];
         if (wb_adr_i == RTR_TESTMODE_OFS && wb_sel_i[0])
            tmode_ff <= wb_dat_i[RTR_TMODE_LSB +: 4];
         if (wb_adr_i == RTR_DEMODTUNE_OFS && wb_sel_i[1:0] == 2'h3)
            tune_ff <= wb_dat_i[11:0];
      end
   end

   // test dac settings; any write to it switches the dac on
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dac_ff <= '0;
         dac_on_ff <= 1'b0;
      end else if (wr && wb_adr_i == RTR_TESTDAC_OFS) begin
         dac_ff.offset <= wv[RTR_DAC_OFS_LSB +: 16];
         dac_ff.gain <= wv[RTR_DAC_GAIN_LSB +: 4];
         dac_ff.sel_corr <= wv[RTR_DAC_SEL_BIT];
         dac_on_ff <= 1'b1;
      end
   end

   // clock dividers and the radio halving select
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         demdiv_ff <= RTR_DEMDIV_RST;
         recdiv_ff <= RTR_RECDIV_RST;
         seqdiv_ff <= RTR_SEQDIV_RST;
         halve_ff <= 1'b0;
      end else if (wr && wb_adr_i == RTR_CLKCTRL_OFS) begin
         demdiv_ff <= wv[RTR_DEMDIV_LSB +: 8];
         recdiv_ff <= wv[RTR_RECDIV_LSB +: 8];
         seqdiv_ff <= wv[RTR_SEQDIV_LSB +: 8];
         halve_ff <= wv[RTR_HALVE_BIT];
      end
   end

   // ----------------------------------------------------------------
   // clock ticks: demod, recovery (from demod) and sequencer
   // ----------------------------------------------------------------
   // a divider of zero is treated as one to avoid a stuck tick
   logic [7:0] dem_cnt_ff;
   logic [7:0] rec_cnt_ff;
   logic [7:0] seq_cnt_ff;
   logic dem_tick_ff;
   logic rec_tick_ff;
   logic seq_tick_ff;
   logic dem_wrap;
   logic rec_wrap;
   logic seq_wrap;

   assign dem_wrap = dem_cnt_ff + 8'h1 >= demdiv_ff;
   assign rec_wrap = rec_cnt_ff + 8'h1 >= recdiv_ff;
   assign seq_wrap = seq_cnt_ff + 8'h1 >= seqdiv_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dem_cnt_ff <= 8'h0;
         dem_tick_ff <= 1'b0;
      end else begin
         dem_cnt_ff <= dem_wrap ? 8'h0 : dem_cnt_ff + 8'h1;
         dem_tick_ff <= dem_wrap;
      end
   end

   // recovery clock counts demod ticks; divider one runs it at demod
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rec_cnt_ff <= 8'h0;
         rec_tick_ff <= 1'b0;
      end else begin
         if (dem_wrap) rec_cnt_ff <= rec_wrap ? 8'h0 : rec_cnt_ff + 8'h1;
         rec_tick_ff <= dem_wrap && rec_wrap;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seq_cnt_ff <= 8'h0;
         seq_tick_ff <= 1'b0;
      end else begin
         seq_cnt_ff <= seq_wrap ? 8'h0 : seq_cnt_ff + 8'h1;
         seq_tick_ff <= seq_wrap;
      end
   end

   // recovered data is only valid while recovery runs below demod
   logic rec_valid_ff;
   logic rec_bit_ff;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rec_valid_ff <= 1'b0;
         rec_bit_ff <= 1'b0;
      end else begin
         rec_valid_ff <= recdiv_ff > 8'h1;
         rec_bit_ff <= (recdiv_ff > 8'h1) && recovered_bit_i;
      end
   end

   // ----------------------------------------------------------------
   // envelope threshold and gain control loop
   // ----------------------------------------------------------------
   logic [RW-1:0] env_ff;
   logic [1:0] gain_step_ff;
   logic [1:0] lna_ff;

   // envelope threshold tracks rssi peaks and leaks; lock freezes it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         env_ff <= '0;
      end else if (!lock_ff && dem_tick_ff) begin
         if (rssi_i > env_ff) env_ff <= rssi_i;
         else if (env_ff != '0) env_ff <= env_ff - RW'(1);
      end
   end

   // gain steps once per sequencer tick between the two thresholds
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gain_step_ff <= 2'h3;
      end else if (seq_tick_ff && !lock_ff) begin
         if (rssi_i < RW'(gain_ff.low) && gain_step_ff != 2'h3)
            gain_step_ff <= gain_step_ff + 2'h1;
         else if (rssi_i > RW'(gain_ff.high) && gain_step_ff != 2'h0)
            gain_step_ff <= gain_step_ff - 2'h1;
      end
   end

   // amplifier gain; the gain-30 code is withheld in the other mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lna_ff <= 2'h0;
      end else begin
         lna_ff <= (gain_ff.low_noise_amp_gain_mode && gain_step_ff == RTR_LNA_GAIN30)
                   ? RTR_LNA_GAIN_CAP : gain_step_ff;
      end
   end

   // ----------------------------------------------------------------
   // correction range, tuning gate and switch control
   // ----------------------------------------------------------------
   logic [19:0] range_ff;
   logic [19:0] span;
   logic [11:0] tune_q_ff;
   logic trsw_ff;
   logic hold_ff;

   // limit times 500 Hz; product widened first so it cannot wrap
   assign span = 20'(freq_ff.limit) * 20'(RTR_STEP_HZ);

   // halved when the radio divides by two
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         range_ff <= '0;
      end else begin
         range_ff <= halve_ff ? span >> 1 : span;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tune_q_ff <= '0;
         trsw_ff <= 1'b1;
         hold_ff <= 1'b0;
      end else begin
         tune_q_ff <= (tmode_ff == RTR_TUNE_KEY) ? tune_ff : '0;
         trsw_ff <= !pdtest_ff[RTR_TRSW_OFF_BIT];
         hold_ff <= lock_ff;
      end
   end

   // ----------------------------------------------------------------
   // test dac path
   // ----------------------------------------------------------------
   logic signed [SW-1:0] pick_ff;
   logic signed [SW-1:0] scaled_ff;
   logic signed [SW+15:0] diff;
   logic sd_bit;
   logic swd_ff;

   // samples are taken on demod ticks, where the filters update
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pick_ff <= '0;
      end else if (dem_tick_ff) begin
         pick_ff <= dac_ff.sel_corr ? corr_sample_i : lin_sample_i;
      end
   end

   // offset removal and power-of-two gain; saturates at full scale
   always_comb begin
      diff = (SW+16)'(pick_ff) - (SW+16)'($signed(dac_ff.offset));
      diff = diff <<< dac_ff.gain;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scaled_ff <= '0;
      end else begin
         scaled_ff <= sat(diff);
      end
   end

   // modulator advances on recovery ticks
   rtr_sigma_delta #(
      .W(SW)
   ) u_sd (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(dac_on_ff),
      .tick_i(rec_tick_ff),
      .x_i(scaled_ff),
      .bit_o(sd_bit)
   );

   // pin carries the bitstream only while the dac is on
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         swd_ff <= 1'b0;
      end else begin
         swd_ff <= dac_on_ff ? sd_bit : sync_det_i;
      end
   end

   // ----------------------------------------------------------------
   // read back and acknowledge
   // ----------------------------------------------------------------
   always_comb begin
      case (wb_adr_i)
         RTR_PDTEST_OFS: nxt_rdat = pdtest_ff;
         RTR_GAINCTRL_OFS: nxt_rdat = {6'h0, gain_ff.low_noise_amp_gain_mode, 7'h0,
            gain_ff.lna_gain, 1'b0, gain_ff.high, 1'b0, gain_ff.low};
         RTR_FREQCORR_OFS: nxt_rdat = {freq_ff.limit, 5'h0, freq_ff.kp,
            freq_ff.ki, freq_ff.scale};
         RTR_THRESH_OFS: nxt_rdat = {31'h0, lock_ff};
         RTR_TESTMODE_OFS: nxt_rdat = {24'h0, tmode_ff, 4'h0};
         RTR_DEMODTUNE_OFS: nxt_rdat = {20'h0, tune_ff};
         RTR_TESTDAC_OFS: nxt_rdat = {11'h0, dac_ff};
         RTR_CLKCTRL_OFS: nxt_rdat = {7'h0, halve_ff, seqdiv_ff,
            recdiv_ff, demdiv_ff};
         RTR_STATUS_OFS: nxt_rdat = {range_ff, 2'h0, lna_ff,
            4'h0, rec_valid_ff, hold_ff, dac_on_ff, 1'b0};
         default: nxt_rdat = RTR_ZERO;
      endcase
   end

   // one wait state; ack drops in the cycle after it was given
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         rdat_ff <= RTR_ZERO;
      end else begin
         ack_ff <= req;
         rdat_ff <= req ? nxt_rdat : RTR_ZERO;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;
   assign trsw_enable_o = trsw_ff;
   assign lna_gain_o = lna_ff;
   assign loop_hold_o = hold_ff;
   assign demod_tick_o = dem_tick_ff;
   assign recovery_tick_o = rec_tick_ff;
   assign recovered_valid_o = rec_valid_ff;
   assign recovered_bit_o = rec_bit_ff;
   assign tune_o = tune_q_ff;
   assign corr_range_hz_o = range_ff;
   assign swd_o = swd_ff;

endmodule // rtr_regs

/* File: hdl/rtr_sigma_delta.sv */
// rtr_sigma_delta: second-order error feedback one-bit modulator.
// assumes x_i holds steady between ticks; advances only on tick_i.
`timescale 1ns/1ps
module rtr_sigma_delta
   import rtr_pkg::*;
#(
   parameter int W = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic tick_i,
   input wire logic signed [W-1:0] x_i,
   output logic bit_o
);

   localparam int AW = W + 4;
   localparam logic signed [AW-1:0] FS = AW'(1 <<< (W-1));

   logic signed [AW-1:0] err1_ff;
   logic signed [AW-1:0] err2_ff;
   logic signed [AW-1:0] v;
   logic signed [AW-1:0] q;
   logic bit_ff;

   // loop sum: input plus shaped error of the last two samples
   always_comb begin
      v = AW'(x_i) + (err1_ff <<< 1) - err2_ff;
      q = (v >= 0) ? FS : -FS;
   end

   // error history; held at zero while stopped so a restart is clean
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         err1_ff <= '0;
         err2_ff <= '0;
      end else if (tick_i) begin
         err1_ff <= v - q;
         err2_ff <= err1_ff;
      end
   end

   // output bit
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         bit_ff <= 1'b0;
      end else if (tick_i) begin
         bit_ff <= (v >= 0);
      end
   end

   assign bit_o = bit_ff;

endmodule // rtr_sigma_delta

/* File: shared/rtr_pkg.sv */
// rtr_pkg: register map, field layouts, reset values and carriers
// for the receive tuning register bank and its test dac.
// assumes a 32-bit classic wishbone bus with word-aligned registers.
package rtr_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] RTR_PDTEST_OFS = 8'h00;
   localparam logic [7:0] RTR_GAINCTRL_OFS = 8'h04;
   localparam logic [7:0] RTR_FREQCORR_OFS = 8'h08;
   localparam logic [7:0] RTR_THRESH_OFS = 8'h0C;
   localparam logic [7:0] RTR_TESTMODE_OFS = 8'h10;
   localparam logic [7:0] RTR_DEMODTUNE_OFS = 8'h14;
   localparam logic [7:0] RTR_TESTDAC_OFS = 8'h18;
   localparam logic [7:0] RTR_CLKCTRL_OFS = 8'h1C;
   localparam logic [7:0] RTR_STATUS_OFS = 8'h20;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int RTR_TRSW_OFF_BIT = 11;
   localparam int RTR_LOW_LSB = 0;
   localparam int RTR_HIGH_LSB = 8;
   localparam int RTR_LNA_GAIN_LSB = 16;
   localparam int RTR_LOW_NOISE_AMP_GAIN_MODE_BIT = 25;
   localparam int RTR_SCALE_LSB = 0;
   localparam int RTR_KI_LSB = 12;
   localparam int RTR_KP_LSB = 16;
   localparam int RTR_LIMIT_LSB = 24;
   localparam int RTR_LOCK_BIT = 0;
   localparam int RTR_TMODE_LSB = 4;
   localparam int RTR_STRETCH_LSB = 0;
   localparam int RTR_LEAK_LSB = 4;
   localparam int RTR_PEAK_LSB = 8;
   localparam int RTR_DAC_OFS_LSB = 0;
   localparam int RTR_DAC_GAIN_LSB = 16;
   localparam int RTR_DAC_SEL_BIT = 20;
   localparam int RTR_DEMDIV_LSB = 0;
   localparam int RTR_RECDIV_LSB = 8;
   localparam int RTR_SEQDIV_LSB = 16;
   localparam int RTR_HALVE_BIT = 24;

   // ----------------------------------------------------------------
   // reset values and constants
   // ----------------------------------------------------------------
   localparam logic [6:0] RTR_LOW_RST = 7'h1E;    // 30
   localparam logic [6:0] RTR_HIGH_RST = 7'h46;   // 70
   localparam logic [3:0] RTR_KI_RST = 4'hB;      // 11
   localparam logic [2:0] RTR_KP_RST = 3'h4;      // 4
   localparam logic [11:0] RTR_SCALE_RST = 12'h000;
   localparam logic [7:0] RTR_LIMIT_RST = 8'h00;
   localparam logic [3:0] RTR_TUNE_KEY = 4'h9;
   localparam logic [1:0] RTR_LNA_GAIN30 = 2'h3;  // code of gain 30
   localparam logic [1:0] RTR_LNA_GAIN_CAP = 2'h2;
   localparam logic [15:0] RTR_STEP_HZ = 16'h01F4; // 500 Hz per step
   localparam logic [7:0] RTR_DEMDIV_RST = 8'h04;
   localparam logic [7:0] RTR_RECDIV_RST = 8'h08;
   localparam logic [7:0] RTR_SEQDIV_RST = 8'hC8;
   localparam logic [31:0] RTR_ZERO = 32'h0000_0000;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic low_noise_amp_gain_mode;
      logic [1:0] lna_gain;
      logic [6:0] high;
      logic [6:0] low;
   } rtr_gain_cfg_t;

   typedef struct packed {
      logic [7:0] limit;
      logic [2:0] kp;
      logic [3:0] ki;
      logic [11:0] scale;
   } rtr_freq_cfg_t;

   typedef struct packed {
      logic sel_corr;
      logic [3:0] gain;
      logic [15:0] offset;
   } rtr_dac_cfg_t;

   typedef struct packed {
      logic [3:0] peak;
      logic [3:0] leak;
      logic [3:0] stretch;
   } rtr_tune_t;

endpackage

/* File: verification/rtr_regs_checker.sv */
// rtr_regs_checker: bus and output rules of rtr_regs
// assumes one clock, synchronous active high reset
`timescale 1ns/1ps
module rtr_regs_checker
   import rtr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic sync_det_i,
   input wire logic trsw_enable_o,
   input wire logic loop_hold_o,
   input wire logic recovered_valid_o,
   input wire logic recovered_bit_o,
   input wire logic [11:0] tune_o,
   input wire logic [19:0] corr_range_hz_o,
   input wire logic swd_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic dac_wr_ff;
   // dac only turns on after a write, so track it here
   always_ff @(posedge clk_i) begin
      if (rst_i)
         dac_wr_ff <= 1'b0;
      else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == RTR_TESTDAC_OFS)
         dac_wr_ff <= 1'b1;
   end
   sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
   property p_handshake; s_take |=> s_ans; endproperty
   property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
   property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
   property p_rst_vals; $fell(rst_i) |-> trsw_enable_o && !loop_hold_o
      && tune_o == 12'h0 && corr_range_hz_o == 20'h0; endproperty
   property p_swd_off; !dac_wr_ff && !$past(rst_i)
      |-> swd_o == $past(sync_det_i); endproperty
   property p_rec_gate; !recovered_valid_o && !$past(recovered_valid_o)
      |-> !recovered_bit_o; endproperty
   property p_cfg_cause; $changed({loop_hold_o, trsw_enable_o})
      |-> $past(wb_cyc_i && wb_we_i) || $past(wb_cyc_i && wb_we_i, 2);
   endproperty
   property p_calc_cause; $changed({tune_o, corr_range_hz_o})
      |-> $past(wb_cyc_i && wb_we_i) || $past(wb_cyc_i && wb_we_i, 2);
   endproperty
   a_handshake: assert property (p_handshake)
      else $error("ack timing");
   a_ack_cause: assert property (p_ack_cause)
      else $error("stray ack");
   a_dat_idle: assert property (p_dat_idle)
      else $error("data off ack");
   a_rst_vals: assert property (p_rst_vals)
      else $error("reset values");
   a_swd_off: assert property (p_swd_off)
      else $error("sync path");
   a_rec_gate: assert property (p_rec_gate)
      else $error("bit not gated");
   a_cfg_cause: assert property (p_cfg_cause)
      else $error("lock moved");
   a_calc_cause: assert property (p_calc_cause)
      else $error("tune moved");
endmodule // rtr_regs_checker
bind rtr_regs rtr_regs_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .sync_det_i, .trsw_enable_o,
   .loop_hold_o, .recovered_valid_o, .recovered_bit_o, .tune_o,
   .corr_range_hz_o, .swd_o);

/* File: verification/rtr_regs_tb_top.sv */
// rtr_regs_tb_top: directed register and test dac checks
// assumes package, design, model and checker compiled first
`timescale 1ns/1ps
module rtr_regs_tb_top;
   import rtr_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic signed [15:0] lin_sample_i, corr_sample_i;
   logic [6:0] rssi_i;
   logic sync_det_i, recovered_bit_i, wb_ack_o, trsw_enable_o, loop_hold_o;
   logic demod_tick_o, recovery_tick_o, recovered_valid_o, recovered_bit_o;
   logic swd_o;
   logic [1:0] lna_gain_o;
   logic [11:0] tune_o;
   logic [19:0] corr_range_hz_o;
   int err_total = 0, cmp_count = 0;
   always #25 clk_i = ~clk_i;
   rtr_rx_model u_rx (.clk_i, .lin_o(lin_sample_i), .corr_o(corr_sample_i),
      .rssi_o(rssi_i), .sync_o(sync_det_i), .bit_o(recovered_bit_i));
   rtr_regs dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .lin_sample_i,
      .corr_sample_i, .rssi_i, .sync_det_i, .recovered_bit_i,
      .trsw_enable_o, .lna_gain_o, .loop_hold_o, .demod_tick_o,
      .recovery_tick_o, .recovered_valid_o, .recovered_bit_o, .tune_o,
      .corr_range_hz_o, .swd_o);
   task automatic chk(input string nm, input logic [31:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic end_of_test;
      if (err_total == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // one classic cycle; held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 16);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 16) begin
         err_total++;
         end_of_test();
      end
      repeat (3) @(posedge clk_i);
   endtask
   task automatic s_regs;
      wb(1'h0, RTR_GAINCTRL_OFS, 32'h0);
      chk("gain reg", q, 32'h0003_461E);
      wb(1'h0, RTR_FREQCORR_OFS, 32'h0);
      chk("freq reg", q, 32'h0004_B000);
      wb(1'h0, RTR_CLKCTRL_OFS, 32'h0);
      chk("clk reg", q, 32'h00C8_0804);
      wb(1'h0, 8'h40, 32'h0);
      chk("unmapped", q, 32'h0);
      wb(1'h1, RTR_PDTEST_OFS, 32'h0000_0800);
      chk("switch off", trsw_enable_o, 1'h0);
      wb(1'h1, RTR_PDTEST_OFS, 32'h0);
      chk("switch on", trsw_enable_o, 1'h1);
      wb(1'h1, RTR_THRESH_OFS, 32'h1);
      chk("hold", loop_hold_o, 1'h1);
      wb(1'h1, RTR_THRESH_OFS, 32'h0);
   endtask
   // thresholds 20 and 100, far apart, around the model's level
   task automatic s_lna;
      wb(1'h1, RTR_GAINCTRL_OFS, 32'h0203_6414);
      wb(1'h0, RTR_GAINCTRL_OFS, 32'h0);
      chk("gain readback", q, 32'h0203_6414);
      repeat (250) @(posedge clk_i);
      chk("lna capped", lna_gain_o, RTR_LNA_GAIN_CAP);
      wb(1'h1, RTR_GAINCTRL_OFS, 32'h0003_6414);
      repeat (250) @(posedge clk_i);
      chk("lna full", lna_gain_o, RTR_LNA_GAIN30);
      // rssi above a high level of 40 walks the gain down to zero
      wb(1'h1, RTR_GAINCTRL_OFS, 32'h0000_2805);
      repeat (700) @(posedge clk_i);
      chk("lna stepped", lna_gain_o, 2'h0);
   endtask
   task automatic s_tune;
      wb(1'h1, RTR_FREQCORR_OFS, 32'h1404_B000);
      chk("range", corr_range_hz_o, 20'h02710);
      wb(1'h1, RTR_CLKCTRL_OFS, 32'h01C8_0804);
      chk("range half", corr_range_hz_o, 20'h01388);
      wb(1'h1, RTR_DEMODTUNE_OFS, 32'h0000_0ABC);
      wb(1'h1, RTR_TESTMODE_OFS, 32'h80);
      chk("tune locked", tune_o, 12'h0);
      wb(1'h1, RTR_TESTMODE_OFS, 32'h90);
      chk("tune open", tune_o, 12'hABC);
   endtask
   task automatic s_clk;
      int nd, nr;
      nd = 0;
      nr = 0;
      repeat (320) begin
         @(posedge clk_i);
         nd += demod_tick_o;
         nr += recovery_tick_o;
      end
      chk("demod ticks", nd, 80);
      chk("rec ticks", nr, 10);
      wb(1'h1, RTR_CLKCTRL_OFS, 32'h00C8_0104);
      chk("rec valid", recovered_valid_o, 1'h0);
      wb(1'h1, RTR_CLKCTRL_OFS, 32'h00C8_0804);
   endtask
   // ones density in quarters: lin, corr, offset, offset with gain
   task automatic s_dac;
      logic [31:0] cfg [4] = '{32'h0, 32'h0010_0000, 32'h4000, 32'h0001_2000};
      int exp_q [4] = '{3, 1, 2, 3};
      int ones;
      for (int i = 0; i < 4; i++) begin
         wb(1'h1, RTR_TESTDAC_OFS, cfg[i]);
         repeat (300) @(posedge clk_i);
         ones = 0;
         repeat (4096) begin
            @(posedge clk_i);
            ones += swd_o;
         end
         chk("density", (ones + 128) / 256, exp_q[i] * 4);
      end
   endtask
   // reset in mid-run must bring the fields back to their defaults
   task automatic s_rst;
      rst_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'h0, RTR_FREQCORR_OFS, 32'h0);
      chk("freq after reset", q, 32'h0004_B000);
      chk("tune after reset", tune_o, 12'h0);
      chk("lna after reset", lna_gain_o, RTR_LNA_GAIN30);
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      s_regs();
      s_lna();
      s_tune();
      s_clk();
      s_dac();
      s_rst();
      end_of_test();
   end
endmodule // rtr_regs_tb_top

/* File: verification/rtr_rx_model.sv */
// rtr_rx_model: receive front end feeding the register bank
// assumes one clock; lines move only after rising edges
`timescale 1ns/1ps
module rtr_rx_model (
   input wire logic clk_i,
   output logic signed [15:0] lin_o,
   output logic signed [15:0] corr_o,
   output logic [6:0] rssi_o,
   output logic sync_o,
   output logic bit_o
);
   logic [3:0] cnt_ff = 4'h0;
   // steady 16-bit filter outputs of opposite sign per path
   assign lin_o = 16'sh4000;
   assign corr_o = 16'shC000;
   // level inside the reset gain window of 30 to 70 so gain holds there
   assign rssi_o = 7'h32;
   assign sync_o = cnt_ff[2];
   assign bit_o = cnt_ff[0];
   // free count gives moving sync and data lines
   always_ff @(posedge clk_i) cnt_ff <= cnt_ff + 4'h1;
endmodule // rtr_rx_model
